/* design/rfspc_pkg.sv */
// Constants, types and the register map of the self-programming controller.
// Assumes a 100 MHz system clock and word-addressed flash of 64K words.
package rfspc_pkg;

  // ****************************************************************
  // Sizes and timing.
  // ****************************************************************
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_ADDR_W = 4;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_TIME_US = 4500;
  localparam int unsigned US_CNT_W = 20;

  // ****************************************************************
  // Flash regions.
  // ****************************************************************
  localparam logic [ADDR_W-1:0] HALT_START = 16'hf000;
  localparam logic [ADDR_W-1:0] LDR_START_3 = 16'hfe00;
  localparam logic [ADDR_W-1:0] LDR_START_2 = 16'hfc00;
  localparam logic [ADDR_W-1:0] LDR_START_1 = 16'hf800;
  localparam logic [ADDR_W-1:0] LDR_START_0 = 16'hf000;
  localparam logic [1:0] FUSE_RESET = 2'h3;
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam int unsigned LOCK_WR_BIT = 0;

  // ****************************************************************
  // Register map and fields.
  // ****************************************************************
  localparam logic [REG_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [REG_ADDR_W-1:0] REG_IRQ_STAT = 4'h2;
  localparam logic [REG_ADDR_W-1:0] REG_IRQ_MASK = 4'h3;
  localparam int unsigned CTRL_CLR_BUSY = 0;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_HALT = 1;
  localparam int unsigned ST_ACTIVE = 2;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_IGNORED = 1;
  localparam int unsigned EV_REFUSED = 2;
  localparam int unsigned EV_VIOL = 3;
  localparam int unsigned EV_N = 4;
  localparam logic [EV_N-1:0] MASK_RESET = 4'h0;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [0:0] {OP_ERASE = 1'h0, OP_WRITE = 1'h1} rfspc_op_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONC = 3'h2,
    ST_STALL = 3'h4
  } rfspc_state_e;

endpackage

/* design/rfspc_dec_if.sv */
// Interface between the controller and its region decoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface rfspc_dec_if;
  logic [1:0] size_fuses;
  logic [1:0] app_lock;
  logic [1:0] ldr_lock;
  logic [rfspc_pkg::ADDR_W-1:0] pc_addr;
  logic [rfspc_pkg::ADDR_W-1:0] page_addr;
  logic [rfspc_pkg::ADDR_W-1:0] fetch_addr;
  logic pc_in_loader;
  logic page_in_halting;
  logic page_locked;
  logic fetch_in_conc;
  modport dec (
    input size_fuses, app_lock, ldr_lock, pc_addr, page_addr, fetch_addr,
    output pc_in_loader, page_in_halting, page_locked, fetch_in_conc
  );
  modport ctl (
    output size_fuses, app_lock, ldr_lock, pc_addr, page_addr, fetch_addr,
    input pc_in_loader, page_in_halting, page_locked, fetch_in_conc
  );
endinterface

/* design/rfspc_sync.sv */
// Two-flop synchroniser for static pin levels.
// Assumes the inputs change rarely and each bit may settle on its own.
`timescale 1ns/1ps
module rfspc_sync #(
  parameter int unsigned WIDTH = 6,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Levels.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // ****************************************************************
  // One two-flop chain per bit.
  // ****************************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (!rst_b) begin
        meta_r[i] <= RESET_VAL[i];
        sync_r[i] <= RESET_VAL[i];
      end else begin
        meta_r[i] <= async_in[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  assign sync_out = sync_r;
endmodule

/* design/rfspc_region_decode.sv */
// Region decoder: loader bounds from the fuses, fixed halting boundary, locks.
// Assumes word addresses and static fuse and lock inputs.
`timescale 1ns/1ps
module rfspc_region_decode (
  // Decoder side of the carrier.
  rfspc_dec_if.dec d
);
  logic [rfspc_pkg::ADDR_W-1:0] ldr_start;
  logic page_in_loader;

  // ****************************************************************
  // Loader start from the size fuses.
  // ****************************************************************
  always_comb begin
    case (d.size_fuses)
      2'h3: ldr_start = rfspc_pkg::LDR_START_3;
      2'h2: ldr_start = rfspc_pkg::LDR_START_2;
      2'h1: ldr_start = rfspc_pkg::LDR_START_1;
      default: ldr_start = rfspc_pkg::LDR_START_0;
    endcase
  end

  // ****************************************************************
  // Classification.
  // ****************************************************************
  assign d.pc_in_loader = d.pc_addr >= ldr_start;
  assign page_in_loader = d.page_addr >= ldr_start;
  assign d.page_in_halting = d.page_addr >= rfspc_pkg::HALT_START;
  assign d.fetch_in_conc = d.fetch_addr < rfspc_pkg::HALT_START;
  // Pair 1/0 and 0/0 both leave the write bit programmed.
  assign d.page_locked = page_in_loader ?
    !d.ldr_lock[rfspc_pkg::LOCK_WR_BIT] : !d.app_lock[rfspc_pkg::LOCK_WR_BIT];
endmodule

/* design/rww_flash_self_program_control.sv */
// Top of the flash self-programming controller.
// Assumes the CPU issues one-cycle store requests on this clock and that
// fuses and lock sets arrive as pins from outside the clock domain.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module rww_flash_self_program_control #(
  parameter int unsigned PROG_TIME_US = rfspc_pkg::PROG_TIME_US
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Register port.
  input wire logic [rfspc_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [rfspc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rfspc_pkg::DATA_W-1:0] reg_rdata,
  // Program store requests from the CPU.
  input wire logic store_req,
  input wire rfspc_pkg::rfspc_op_e store_kind,
  input wire logic [rfspc_pkg::ADDR_W-1:0] store_pc,
  input wire logic [rfspc_pkg::ADDR_W-1:0] store_page,
  // Instruction fetch check.
  input wire logic fetch_req,
  input wire logic [rfspc_pkg::ADDR_W-1:0] fetch_addr,
  output logic fetch_grant,
  output logic fetch_deny,
  // Fuse and lock pins.
  input wire logic [1:0] loader_size_fuses,
  input wire logic [1:0] application_lock_set,
  input wire logic [1:0] loader_lock_set,
  // Flash array and CPU control.
  output logic flash_start,
  output logic flash_erase,
  output logic [rfspc_pkg::ADDR_W-1:0] flash_page,
  output logic cpu_halt,
  output logic concurrent_region_busy_flag,
  // Interrupt.
  output logic irq
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  localparam logic [5:0] PIN_RESET = {rfspc_pkg::FUSE_RESET, rfspc_pkg::LOCK_RESET,
                                      rfspc_pkg::LOCK_RESET};
  localparam logic [7:0] TICK_LAST = 8'(rfspc_pkg::TICK_CYC - 1);
  localparam logic [rfspc_pkg::US_CNT_W-1:0] US_LAST =
    rfspc_pkg::US_CNT_W'(PROG_TIME_US - 1);

  rfspc_pkg::rfspc_state_e state_r;
  logic [5:0] pins_sync;
  logic [7:0] tick_cnt_r;
  logic tick_en;
  logic [rfspc_pkg::US_CNT_W-1:0] us_cnt_r;
  logic prog_done;
  logic idle;
  logic start_ok;
  logic start_conc;
  logic ev_ignored;
  logic ev_refused;
  logic ev_viol;
  logic conc_blocked;
  logic clr_busy;
  logic busy_r;
  logic halt_r;
  logic start_r;
  logic erase_r;
  logic [rfspc_pkg::ADDR_W-1:0] page_r;
  logic grant_r;
  logic deny_r;
  logic [rfspc_pkg::EV_N-1:0] events;
  logic [rfspc_pkg::EV_N-1:0] irq_stat_r;
  logic [rfspc_pkg::EV_N-1:0] irq_stat_nxt;
  logic [rfspc_pkg::EV_N-1:0] irq_mask_r;
  logic irq_r;
  logic [rfspc_pkg::DATA_W-1:0] rdata_r;
  logic [rfspc_pkg::DATA_W-1:0] rdata_nxt;

  rfspc_dec_if dec_if ();

  // ****************************************************************
  // Pin synchronisers and region decoder.
  // ****************************************************************
  rfspc_sync #(
    .WIDTH(6),
    .RESET_VAL(PIN_RESET)
  ) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({loader_size_fuses, application_lock_set, loader_lock_set}),
    .sync_out(pins_sync)
  );

  assign dec_if.size_fuses = pins_sync[5:4];
  assign dec_if.app_lock = pins_sync[3:2];
  assign dec_if.ldr_lock = pins_sync[1:0];
  assign dec_if.pc_addr = store_pc;
  assign dec_if.page_addr = store_page;
  assign dec_if.fetch_addr = fetch_addr;

  rfspc_region_decode u_dec (
    .d(dec_if.dec)
  );

  // ****************************************************************
  // Request qualification.
  // ****************************************************************
  assign idle = state_r == rfspc_pkg::ST_IDLE;
  assign ev_ignored = store_req && !dec_if.pc_in_loader;
  assign start_ok = store_req && dec_if.pc_in_loader && idle && !dec_if.page_locked;
  assign ev_refused = store_req && dec_if.pc_in_loader && !start_ok;
  assign start_conc = start_ok && !dec_if.page_in_halting;
  assign clr_busy = reg_wr && reg_addr == rfspc_pkg::REG_CTRL &&
                    reg_wdata[rfspc_pkg::CTRL_CLR_BUSY] && idle;

  // ****************************************************************
  // Microsecond divider and operation timer.
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b || idle) begin
      tick_cnt_r <= 8'h00;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
    end
  end

  assign tick_en = !idle && tick_cnt_r == TICK_LAST;
  assign prog_done = tick_en && us_cnt_r == US_LAST;

  always_ff @(posedge clock) begin
    if (!rst_b || idle) begin
      us_cnt_r <= '0;
    end else if (tick_en) begin
      us_cnt_r <= us_cnt_r + rfspc_pkg::US_CNT_W'(1);
    end
  end

  // ****************************************************************
  // Operation state machine.
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= rfspc_pkg::ST_IDLE;
    end else begin
      case (state_r)
        rfspc_pkg::ST_IDLE: begin
          if (start_conc) begin
            state_r <= rfspc_pkg::ST_CONC;
          end else if (start_ok) begin
            state_r <= rfspc_pkg::ST_STALL;
          end
        end
        rfspc_pkg::ST_CONC, rfspc_pkg::ST_STALL: begin
          if (prog_done) begin
            state_r <= rfspc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= rfspc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // CPU halt for halting-region pages.
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      halt_r <= 1'b0;
    end else if (start_ok && dec_if.page_in_halting) begin
      halt_r <= 1'b1;
    end else if (prog_done) begin
      halt_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Flash array command.
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      start_r <= 1'b0;
      erase_r <= 1'b0;
      page_r <= '0;
    end else begin
      start_r <= start_ok;
      if (start_ok) begin
        erase_r <= store_kind == rfspc_pkg::OP_ERASE;
        page_r <= store_page;
      end
    end
  end

  // ****************************************************************
  // Concurrent-read region busy flag.
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
    end else if (start_conc) begin
      busy_r <= 1'b1;
    end else if (clr_busy) begin
      busy_r <= 1'b0;
    end
  end

  assign conc_blocked = busy_r || start_conc;

  // ****************************************************************
  // Instruction fetch check.
  // ****************************************************************
  assign ev_viol = fetch_req && dec_if.fetch_in_conc && conc_blocked;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      grant_r <= 1'b0;
      deny_r <= 1'b0;
    end else begin
      grant_r <= fetch_req && !halt_r && !ev_viol;
      deny_r <= fetch_req && (halt_r || ev_viol);
    end
  end

  // ****************************************************************
  // Interrupt status, mask and output.
  // ****************************************************************
  always_comb begin
    events = '0;
    events[rfspc_pkg::EV_DONE] = prog_done;
    events[rfspc_pkg::EV_IGNORED] = ev_ignored;
    events[rfspc_pkg::EV_REFUSED] = ev_refused;
    events[rfspc_pkg::EV_VIOL] = ev_viol;
    irq_stat_nxt = irq_stat_r;
    if (reg_rd && reg_addr == rfspc_pkg::REG_IRQ_STAT) begin
      irq_stat_nxt = '0;
    end
    irq_stat_nxt = irq_stat_nxt | events;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_mask_r <= rfspc_pkg::MASK_RESET;
    end else if (reg_wr && reg_addr == rfspc_pkg::REG_IRQ_MASK) begin
      irq_mask_r <= reg_wdata[rfspc_pkg::EV_N-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // ****************************************************************
  // Register read port.
  // ****************************************************************
  always_comb begin
    rdata_nxt = '0;
    if (!reg_rd) begin
      rdata_nxt = '0;
    end else if (reg_addr == rfspc_pkg::REG_STATUS) begin
      rdata_nxt[rfspc_pkg::ST_BUSY] = busy_r;
      rdata_nxt[rfspc_pkg::ST_HALT] = halt_r;
      rdata_nxt[rfspc_pkg::ST_ACTIVE] = !idle;
    end else if (reg_addr == rfspc_pkg::REG_IRQ_STAT) begin
      rdata_nxt[rfspc_pkg::EV_N-1:0] = irq_stat_r;
    end else if (reg_addr == rfspc_pkg::REG_IRQ_MASK) begin
      rdata_nxt[rfspc_pkg::EV_N-1:0] = irq_mask_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign reg_rdata = rdata_r;
  assign fetch_grant = grant_r;
  assign fetch_deny = deny_r;
  assign flash_start = start_r;
  assign flash_erase = erase_r;
  assign flash_page = page_r;
  assign cpu_halt = halt_r;
  assign concurrent_region_busy_flag = busy_r;
  assign irq = irq_r;

endmodule

/* tb/rfspc_cpu_model.sv */
// CPU core model issuing program stores and fetch checks.
// Assumes the bench calls its tasks; requests change after a rising edge.
`timescale 1ns/1ps
module rfspc_cpu_model (
  // Clock.
  input wire logic clock,
  // Program store.
  output logic store_req,
  output rfspc_pkg::rfspc_op_e store_kind,
  output logic [15:0] store_pc,
  output logic [15:0] store_page,
  // Fetch check.
  output logic fetch_req,
  output logic [15:0] fetch_addr
);
  initial begin
    store_req = 1'b0;
    store_kind = rfspc_pkg::OP_ERASE;
    store_pc = 16'h0;
    store_page = 16'h0;
    fetch_req = 1'b0;
    fetch_addr = 16'h0;
  end
  // One store; released address lines show the inverse of the last value.
  task automatic store(input rfspc_pkg::rfspc_op_e k, input logic [15:0] pc, input logic [15:0] pg);
    @(posedge clock);
    store_req <= 1'b1;
    store_kind <= k;
    store_pc <= pc;
    store_page <= pg;
    @(posedge clock);
    store_req <= 1'b0;
    store_pc <= ~pc;
    store_page <= ~pg;
  endtask
  // One fetch check; the released address shows the inverse of the last value.
  task automatic fetch(input logic [15:0] a);
    @(posedge clock);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge clock);
    fetch_req <= 1'b0;
    fetch_addr <= ~a;
  endtask
endmodule

/* tb/rfspc_chk.sv */
// Assertions on the ports of the self-programming controller.
// Assumes it is bound into the top module with the op time passed on.
`timescale 1ns/1ps
module rfspc_chk #(
  parameter int unsigned PROG_TIME_US = 2
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Watched ports.
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic store_req,
  input wire logic [15:0] store_pc,
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_grant,
  input wire logic fetch_deny,
  input wire logic flash_start,
  input wire logic [15:0] flash_page,
  input wire logic cpu_halt,
  input wire logic concurrent_region_busy_flag
);
  // ****************************************************************
  // Helper logic and assertions.
  // ****************************************************************
  localparam int N = PROG_TIME_US * 100;
  localparam logic [15:0] HB = rfspc_pkg::HALT_START;
  logic [19:0] halt_cnt_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clock) begin
    if (!rst_b || !cpu_halt) halt_cnt_r <= 20'h0;
    else halt_cnt_r <= halt_cnt_r + 20'h1;
  end
  sequence s_conc_start;
    flash_start && flash_page < HB;
  endsequence
  sequence s_halt_start;
    flash_start && flash_page >= HB;
  endsequence
  a_app_ignored: assert property (
    store_req && store_pc < HB |=> !flash_start) else $error("application store started");
  a_loader_only: assert property (
    flash_start |-> $past(store_req) && $past(store_pc) >= HB)
    else $error("start without loader");
  a_conc_runs: assert property (
    s_conc_start |-> concurrent_region_busy_flag && !cpu_halt)
    else $error("concurrent start wrong");
  a_halt_stall: assert property (
    s_halt_start |-> cpu_halt) else $error("halting start without halt");
  a_halt_length: assert property (
    $fell(cpu_halt) |-> halt_cnt_r >= N - 1 && halt_cnt_r <= N + 1) else $error("halt length");
  a_busy_deny: assert property (
    fetch_req && fetch_addr < HB && concurrent_region_busy_flag |=> fetch_deny && !fetch_grant)
    else $error("busy fetch served");
  a_halted_deny: assert property (
    fetch_req && cpu_halt |=> fetch_deny && !fetch_grant) else $error("halted fetch served");
  a_halting_grant: assert property (
    fetch_req && fetch_addr >= HB && !cpu_halt && !store_req |=> fetch_grant)
    else $error("halting fetch refused");
  a_busy_held: assert property (
    concurrent_region_busy_flag && !(reg_wr && reg_addr == 4'h0 && reg_wdata[0])
    |=> concurrent_region_busy_flag) else $error("busy dropped alone");
  a_busy_read: assert property (
    reg_rd && reg_addr == 4'h1 |=> reg_rdata[0] == $past(concurrent_region_busy_flag))
    else $error("busy read wrong");
endmodule
bind rww_flash_self_program_control rfspc_chk #(.PROG_TIME_US(PROG_TIME_US)) chk (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_req(store_req),
  .store_pc(store_pc), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
  .fetch_grant(fetch_grant), .fetch_deny(fetch_deny), .flash_start(flash_start),
  .flash_page(flash_page), .cpu_halt(cpu_halt),
  .concurrent_region_busy_flag(concurrent_region_busy_flag));

/* tb/test_rww_flash_self_program_control.sv */
// Self-checking bench of the self-programming controller.
// Assumes the CPU model drives the store and fetch ports.
`timescale 1ns/1ps
module test_rww_flash_self_program_control;
  logic clock, rst_b, reg_wr, reg_rd, store_req, fetch_req, fetch_grant, fetch_deny;
  logic flash_start, flash_erase, cpu_halt, busy, irq;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] store_pc, store_page, fetch_addr, flash_page;
  logic [1:0] fuses, app_lock, ldr_lock;
  rfspc_pkg::rfspc_op_e store_kind;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  rww_flash_self_program_control #(.PROG_TIME_US(2)) dut (
    .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_req(store_req),
    .store_kind(store_kind), .store_pc(store_pc), .store_page(store_page),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_grant(fetch_grant),
    .fetch_deny(fetch_deny),
    .loader_size_fuses(fuses), .application_lock_set(app_lock), .loader_lock_set(ldr_lock),
    .flash_start(flash_start), .flash_erase(flash_erase), .flash_page(flash_page),
    .cpu_halt(cpu_halt), .concurrent_region_busy_flag(busy), .irq(irq));
  rfspc_cpu_model cpu (
    .clock(clock), .store_req(store_req), .store_kind(store_kind), .store_pc(store_pc),
    .store_page(store_page), .fetch_req(fetch_req), .fetch_addr(fetch_addr));
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", n, exp, seen);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rd_chk(input string n, input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(n, 16'(d), 16'(e));
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_idle();
    logic [7:0] d;
    d = 8'h04;
    for (int i = 0; i < 400 && d[rfspc_pkg::ST_ACTIVE] === 1'b1; i++) rd(4'h1, d);
    check("active", 16'(d[rfspc_pkg::ST_ACTIVE]), 16'h0);
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_app_ignored();
    rd_chk("mask reset", 4'h3, 8'h00);
    rd_chk("unmapped", 4'hf, 8'h00);
    cpu.store(rfspc_pkg::OP_WRITE, 16'h0100, 16'h0200);
    #1 check("app start", 16'(flash_start), 16'h0);
    settle(2);
    check("irq masked", 16'(irq), 16'h0);
    wr(4'h3, 8'h02);
    settle(1);
    check("irq raised", 16'(irq), 16'h1);
    rd_chk("mask", 4'h3, 8'h02);
    rd_chk("ignored stat", 4'h2, 8'h02);
    settle(1);
    check("irq cleared", 16'(irq), 16'h0);
    wr(4'h3, 8'h00);
  endtask
  task automatic t_conc();
    cpu.store(rfspc_pkg::OP_ERASE, 16'hfe00, 16'h0100);
    #1 check("start", 16'({flash_start, flash_erase, busy, cpu_halt}), 16'he);
    check("conc page", flash_page, 16'h0100);
    cpu.fetch(16'hf010);
    #1 check("halting fetch", 16'(fetch_grant), 16'h1);
    cpu.fetch(16'h0010);
    #1 check("conc fetch", 16'(fetch_deny), 16'h1);
    rd_chk("status run", 4'h1, 8'h05);
    wr(4'h0, 8'h01);
    settle(1);
    check("clear in run", 16'(busy), 16'h1);
    wait_idle();
    check("busy after", 16'(busy), 16'h1);
    rd_chk("irq done", 4'h2, 8'h09);
    wr(4'h0, 8'h01);
    settle(1);
    check("busy cleared", 16'(busy), 16'h0);
  endtask
  task automatic t_halt();
    cpu.store(rfspc_pkg::OP_WRITE, 16'hfe00, 16'hfe00);
    #1 check("halt start", 16'({flash_start, flash_erase, busy, cpu_halt}), 16'h9);
    cpu.fetch(16'hf010);
    #1 check("halted fetch", 16'(fetch_deny), 16'h1);
    cpu.store(rfspc_pkg::OP_WRITE, 16'hfe00, 16'h0100);
    #1 check("second start", 16'(flash_start), 16'h0);
    for (int i = 0; i < 400 && cpu_halt === 1'b1; i++) settle(1);
    check("halt end", 16'(cpu_halt), 16'h0);
    rd_chk("irq refused", 4'h2, 8'h05);
  endtask
  task automatic t_locks();
    @(posedge clock);
    app_lock <= 2'b10;
    settle(3);
    cpu.store(rfspc_pkg::OP_WRITE, 16'hfe00, 16'h0100);
    #1 check("app locked", 16'(flash_start), 16'h0);
    rd_chk("app refused", 4'h2, 8'h04);
    cpu.store(rfspc_pkg::OP_WRITE, 16'hfe00, 16'hfe00);
    #1 check("ldr open", 16'(flash_start), 16'h1);
    wait_idle();
    @(posedge clock);
    app_lock <= 2'b11;
    ldr_lock <= 2'b10;
    settle(3);
    cpu.store(rfspc_pkg::OP_WRITE, 16'hfe00, 16'hfe00);
    #1 check("ldr locked", 16'(flash_start), 16'h0);
    rd_chk("ldr refused", 4'h2, 8'h05);
    @(posedge clock);
    ldr_lock <= 2'b11;
  endtask
  task automatic t_fuses();
    logic [15:0] tab [4] = '{16'hf000, 16'hf800, 16'hfc00, 16'hfe00};
    for (int f = 0; f < 4; f++) begin
      @(posedge clock);
      fuses <= 2'(f);
      settle(3);
      cpu.store(rfspc_pkg::OP_ERASE, tab[f] - 16'h1, 16'hf000);
      #1 check("below loader", 16'(flash_start), 16'h0);
      cpu.store(rfspc_pkg::OP_ERASE, tab[f], 16'hf000);
      #1 check("loader start", 16'({flash_start, cpu_halt}), 16'h3);
      wait_idle();
    end
    rd_chk("fuse events", 4'h2, 8'h03);
  endtask
  // ****************************************************************
  // Clock, reset, timeout and main sequence.
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    fuses = 2'b11;
    app_lock = 2'b11;
    ldr_lock = 2'b11;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    t_app_ignored();
    t_conc();
    t_halt();
    t_locks();
    t_fuses();
    test_done();
  end
endmodule
